// *** rtl/pio_port_io_pin_routing.sv ***
// port 0 pin routing, driver config, input mode, oscillator valid, axi-lite
`timescale 1ns/1ps
module pio_port_io_pin_routing
   import pio_pkg::*;
#(
   parameter int OSC_START_CYC = PIO_OSC_START_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_analog_en,
   input wire logic serial_tx,
   output logic serial_rx,
   output logic timer0_input,
   output logic timer1_input,
   output logic timer2_input,
   output logic timer2_capture_input,
   output logic ext_irq0_input,
   output logic ext_irq1_input,
   input wire logic ext_osc_running,
   output logic ext_osc_enable,
   output logic [2:0] ext_osc_freq_ctl,
   output logic irq
);
   typedef struct packed
   {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] port0_route_reg;
      logic [7:0] port0_out_cfg;
      logic [7:0] port0_input_mode;
      logic [7:0] latch;
      logic [7:0] pin_sync;
      logic osc_en;
      logic [2:0] fcn;
      logic valid_d;
      logic [PIO_IRQ_W-1:0] irq_stat;
      logic [PIO_IRQ_W-1:0] irq_en;
      logic irq;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] analog;
      logic [7:0] periph_in;
      logic serial_rx;
   } pio_st_t;

   pio_st_t st;
   pio_st_t next_st;
   logic osc_valid_flag;
   logic [7:0] drive_val;
   logic [7:0] dig_in;
   logic wr_fire;
   logic [31:0] rd_word;
   logic rd_ok;
   logic valid_rise;
   logic [PIO_IRQ_W-1:0] clr_bits;

   ////////////////////////////////////////////////////////////////////////
   // oscillator valid timer
   pio_osc_valid #(
      .START_CYC(OSC_START_CYC)
   ) u_osc_valid (
      .aclk(aclk),
      .aresetn(aresetn),
      .osc_enable(st.osc_en),
      .osc_running(ext_osc_running),
      .osc_valid_flag(osc_valid_flag)
   );

   ////////////////////////////////////////////////////////////////////////
   // register read mux
   always_comb
   begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         PIO_ADDR_ROUTE: rd_word[7:0] = st.port0_route_reg;
         PIO_ADDR_OUT_CFG: rd_word[7:0] = st.port0_out_cfg;
         PIO_ADDR_IN_MODE: rd_word[7:0] = st.port0_input_mode;
         PIO_ADDR_LATCH: rd_word[7:0] = st.latch;
         PIO_ADDR_PIN_IN: rd_word[7:0] = st.pin_sync;
         PIO_ADDR_OSC_CTRL:
         begin
            rd_word[PIO_OSC_EN] = st.osc_en;
            rd_word[PIO_OSC_FCN_HI:PIO_OSC_FCN_LO] = st.fcn;
            rd_word[PIO_OSC_VALID] = osc_valid_flag;
         end
         PIO_ADDR_IRQ_STAT: rd_word[PIO_IRQ_W-1:0] = st.irq_stat;
         PIO_ADDR_IRQ_EN: rd_word[PIO_IRQ_W-1:0] = st.irq_en;
         PIO_ADDR_IRQ_CLR: rd_word = 32'h00000000; // write-only
         default: rd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // pin driver and input path
   always_comb
   begin
      // routed serial transmit overrides the pin 0 latch
      drive_val = st.latch;
      if (st.port0_route_reg[PIO_RT_UART])
         drive_val[PIO_PIN_TX] = serial_tx;
      dig_in = st.pin_sync & st.port0_input_mode;
   end

   assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
   assign valid_rise = osc_valid_flag && !st.valid_d;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      next_st = st;
      clr_bits = '0;
      next_st.pin_sync = pin_in;
      next_st.valid_d = osc_valid_flag;
      // write address and data captured in either order
      if (s_axi_awvalid && !st.aw_got)
      begin
         next_st.aw_got = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_got)
      begin
         next_st.w_got = 1'b1;
         next_st.w_data = s_axi_wdata[7:0];
         next_st.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = PIO_RESP_OKAY;
         if (st.w_lane0)
         begin
            unique case (st.aw_addr)
               PIO_ADDR_ROUTE:
                  next_st.port0_route_reg =
                     st.w_data & PIO_RT_WMASK;
               PIO_ADDR_OUT_CFG: next_st.port0_out_cfg = st.w_data;
               PIO_ADDR_IN_MODE: next_st.port0_input_mode = st.w_data;
               PIO_ADDR_LATCH: next_st.latch = st.w_data;
               PIO_ADDR_OSC_CTRL:
               begin
                  next_st.osc_en = st.w_data[PIO_OSC_EN];
                  next_st.fcn = st.w_data[PIO_OSC_FCN_HI:PIO_OSC_FCN_LO];
               end
               PIO_ADDR_IRQ_EN: next_st.irq_en = st.w_data[PIO_IRQ_W-1:0];
               PIO_ADDR_IRQ_CLR: clr_bits = st.w_data[PIO_IRQ_W-1:0];
               PIO_ADDR_PIN_IN, PIO_ADDR_IRQ_STAT: ;
               default: next_st.bresp = PIO_RESP_SLVERR;
            endcase
         end
         else if (!(st.aw_addr inside {PIO_ADDR_ROUTE, PIO_ADDR_OUT_CFG,
            PIO_ADDR_IN_MODE, PIO_ADDR_LATCH, PIO_ADDR_PIN_IN,
            PIO_ADDR_OSC_CTRL, PIO_ADDR_IRQ_STAT, PIO_ADDR_IRQ_EN,
            PIO_ADDR_IRQ_CLR}))
            next_st.bresp = PIO_RESP_SLVERR;
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      // read: one cycle after the address is taken
      if (s_axi_arvalid && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = rd_ok ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
      end
      else if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      // sticky status, set wins over clear
      next_st.irq_stat = (st.irq_stat & ~clr_bits);
      if (valid_rise)
         next_st.irq_stat[PIO_IRQ_OSC] = 1'b1;
      next_st.irq = |(next_st.irq_stat & next_st.irq_en);
      // open-drain drives only a low; latch one leaves pin floating
      for (int i = 0; i < 8; i++)
      begin
         next_st.pin_out[i] = drive_val[i];
         if (st.port0_out_cfg[i])
            next_st.pin_oe[i] = 1'b1;
         else
            next_st.pin_oe[i] = !drive_val[i];
      end
      next_st.analog = ~st.port0_input_mode;
      // peripheral inputs gated by their route bits
      next_st.periph_in = dig_in & st.port0_route_reg;
      next_st.serial_rx = st.port0_route_reg[PIO_RT_UART] ?
         dig_in[PIO_PIN_RX] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.port0_route_reg <= PIO_RST_ROUTE;
         st.port0_out_cfg <= PIO_RST_OUT_CFG;
         st.port0_input_mode <= PIO_RST_IN_MODE;
         st.latch <= PIO_RST_LATCH;
         st.pin_out <= PIO_RST_LATCH;
         st.serial_rx <= 1'b1;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_awready = !st.aw_got;
   assign s_axi_wready = !st.w_got;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign pin_out = st.pin_out;
   assign pin_oe = st.pin_oe;
   assign pin_analog_en = st.analog;
   assign serial_rx = st.serial_rx;
   assign timer0_input = st.periph_in[PIO_PIN_T0];
   assign timer1_input = st.periph_in[PIO_PIN_T1];
   assign timer2_input = st.periph_in[PIO_PIN_T2];
   assign timer2_capture_input = st.periph_in[PIO_PIN_TIMER2_CAPTURE_INPUT];
   assign ext_irq0_input = st.periph_in[PIO_PIN_EXT_IRQ0_INPUT];
   assign ext_irq1_input = st.periph_in[PIO_PIN_EXT_IRQ1_INPUT];
   assign ext_osc_enable = st.osc_en;
   assign ext_osc_freq_ctl = st.fcn;
   assign irq = st.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_od_high_float: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.port0_out_cfg[PIO_PIN_T0] && st.latch[PIO_PIN_T0]) |=>
      !pin_oe[PIO_PIN_T0])
      else $error("open-drain high pin is driven");
   a_pp_drives: assert property (@(posedge aclk) disable iff (!aresetn)
      st.port0_out_cfg[PIO_PIN_T1] |=> pin_oe[PIO_PIN_T1])
      else $error("push-pull pin not driven");
   a_t0_route: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.port0_route_reg[PIO_RT_T0] && st.port0_input_mode[PIO_PIN_T0])
      |=> timer0_input == $past(st.pin_sync[PIO_PIN_T0], 1))
      else $error("timer0 not routed from pin 4");
   a_t1_unrouted: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.port0_route_reg[PIO_RT_T1] |=> !timer1_input)
      else $error("unrouted timer1 input active");
   a_bit1_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.port0_route_reg[PIO_RT_UNUSED])
      else $error("route bit 1 not zero");
   a_analog_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 pin_analog_en == ~$past(st.port0_input_mode))
      else $error("analog enable mismatch");
   a_digital_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !st.port0_input_mode[PIO_PIN_EXT_IRQ0_INPUT] |=> !ext_irq0_input)
      else $error("analog pin feeds digital input");
   a_reset_state: assert property (@(posedge aclk)
      !aresetn |=> (pin_out == PIO_RST_LATCH && pin_oe == 8'h00
      && pin_analog_en == 8'h00))
      else $error("bad pin state after reset");
   a_tx_routed: assert property (@(posedge aclk) disable iff (!aresetn)
      st.port0_route_reg[PIO_RT_UART] |=>
      pin_out[PIO_PIN_TX] == $past(serial_tx))
      else $error("serial tx not on pin 0");
endmodule // pio_port_io_pin_routing

// *** rtl/pio_pkg.sv ***
// package: register map, field positions, reset values, timing for port routing
package pio_pkg;
   // register byte addresses on the axi4-lite bus
   localparam logic [7:0] PIO_ADDR_ROUTE = 8'h00;
   localparam logic [7:0] PIO_ADDR_OUT_CFG = 8'h04;
   localparam logic [7:0] PIO_ADDR_IN_MODE = 8'h08;
   localparam logic [7:0] PIO_ADDR_LATCH = 8'h0C;
   localparam logic [7:0] PIO_ADDR_PIN_IN = 8'h10;
   localparam logic [7:0] PIO_ADDR_OSC_CTRL = 8'h14;
   localparam logic [7:0] PIO_ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] PIO_ADDR_IRQ_EN = 8'h1C;
   localparam logic [7:0] PIO_ADDR_IRQ_CLR = 8'h20;
   // routing register fields
   localparam int PIO_RT_TIMER2_CAPTURE_INPUT = 7;
   localparam int PIO_RT_T2 = 6;
   localparam int PIO_RT_T1 = 5;
   localparam int PIO_RT_T0 = 4;
   localparam int PIO_RT_EXT_IRQ1_INPUT = 3;
   localparam int PIO_RT_EXT_IRQ0_INPUT = 2;
   localparam int PIO_RT_UNUSED = 1;
   localparam int PIO_RT_UART = 0;
   localparam logic [7:0] PIO_RT_WMASK = 8'hFD;
   // pin positions on port 0
   localparam int PIO_PIN_TX = 0;
   localparam int PIO_PIN_RX = 1;
   localparam int PIO_PIN_EXT_IRQ0_INPUT = 2;
   localparam int PIO_PIN_EXT_IRQ1_INPUT = 3;
   localparam int PIO_PIN_T0 = 4;
   localparam int PIO_PIN_T1 = 5;
   localparam int PIO_PIN_T2 = 6;
   localparam int PIO_PIN_TIMER2_CAPTURE_INPUT = 7;
   // oscillator control fields
   localparam int PIO_OSC_EN = 0;
   localparam int PIO_OSC_VALID = 7;
   localparam int PIO_OSC_FCN_LO = 1;
   localparam int PIO_OSC_FCN_HI = 3;
   // interrupt status bits
   localparam int PIO_IRQ_OSC = 0;
   localparam int PIO_IRQ_W = 1;
   // reset values
   localparam logic [7:0] PIO_RST_ROUTE = 8'h00;
   localparam logic [7:0] PIO_RST_OUT_CFG = 8'h00;
   localparam logic [7:0] PIO_RST_IN_MODE = 8'hFF;
   localparam logic [7:0] PIO_RST_LATCH = 8'hFF;
   // oscillator start-up time
   localparam int PIO_CLK_MHZ = 100;
   localparam int PIO_OSC_START_US = 1000;
   localparam int PIO_OSC_START_CYC = PIO_OSC_START_US * PIO_CLK_MHZ;
   // axi response codes
   localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;
endpackage

// *** rtl/pio_osc_valid.sv ***
// oscillator stability timer: raises valid after a start-up count
`timescale 1ns/1ps
module pio_osc_valid
   import pio_pkg::*;
#(
   parameter int START_CYC = PIO_OSC_START_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic osc_enable,
   input wire logic osc_running,
   output logic osc_valid_flag
);
   typedef struct packed
   {
      logic [23:0] count;
      logic valid;
   } pio_ov_t;

   pio_ov_t st;
   pio_ov_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // count stable running time, drop on disable or stop
   always_comb
   begin
      next_st = st;
      if (!osc_enable || !osc_running)
      begin
         next_st.count = 24'h000000;
         next_st.valid = 1'b0;
      end
      else if (st.count >= 24'(START_CYC - 1))
         next_st.valid = 1'b1;
      else
         next_st.count = st.count + 24'h000001;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign osc_valid_flag = st.valid;

   a_valid_needs_run: assert property (@(posedge aclk) disable iff (!aresetn)
      osc_valid_flag |-> osc_enable || $past(osc_enable))
      else $error("valid without enabled oscillator");
endmodule // pio_osc_valid

// *** sim/pio_pin_model.sv ***
// partner model: port pins with pull-up, external drivers, oscillator
`timescale 1ns/1ps
module pio_pin_model
#(
   parameter int RUN_DLY = 4
)
(
   input wire logic aclk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   input wire logic osc_enable,
   output logic [7:0] pin_level,
   output logic osc_running
);
   logic [RUN_DLY-1:0] osc_shift = '0;

   // wire level: device driver first, then outside source, else pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pin_oe[i])
            pin_level[i] = pin_out[i];
         else if (ext_en[i])
            pin_level[i] = ext_val[i];
         else
            pin_level[i] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator starts a few cycles after enable, stops at once
   always_ff @(posedge aclk)
      osc_shift <= osc_enable ? {osc_shift[RUN_DLY-2:0], 1'b1} : '0;
   assign osc_running = osc_shift[RUN_DLY-1] & osc_enable;
endmodule // pio_pin_model

// *** sim/pio_port_io_pin_routing_bench.sv ***
// testbench: register access, pin routing, driver modes, oscillator
`timescale 1ns/1ps
module pio_port_io_pin_routing_bench;
   import pio_pkg::*;
   localparam int SIM_START = 20;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic serial_tx = 1'b1;
   logic [7:0] ext_en = 8'h00;
   logic [7:0] ext_val = 8'hFF;
   logic awready, wready, bvalid, arready, rvalid, serial_rx, irq;
   logic t0, t1, t2, t2c, x0, x1, osc_en, osc_run;
   logic [2:0] fcn;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [7:0] pin_in, pin_out, pin_oe, pin_analog_en;
   logic [5:0] routed;
   int errors = 0;
   int checked = 0;

   // clock
   always #5 aclk = ~aclk;
   assign routed = {t2c, t2, t1, t0, x1, x0};

   ////////////////////////////////////////////////////////////////////////
   // design and far-side model
   pio_port_io_pin_routing #(.OSC_START_CYC(SIM_START))
      pio_port_io_pin_routing_i
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_analog_en(pin_analog_en), .serial_tx(serial_tx),
      .serial_rx(serial_rx), .timer0_input(t0), .timer1_input(t1),
      .timer2_input(t2), .timer2_capture_input(t2c),
      .ext_irq0_input(x0), .ext_irq1_input(x1),
      .ext_osc_running(osc_run), .ext_osc_enable(osc_en),
      .ext_osc_freq_ctl(fcn), .irq(irq)
   );
   pio_pin_model pio_pin_model_i
   (
      .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .osc_enable(osc_en), .pin_level(pin_in),
      .osc_running(osc_run)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers: compare, verdict, bus cycles
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      while (n < 100)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
         n++;
      end
      rsp = bresp;
      bready <= 1'b0;
      if (n == 100) errors++;
   endtask

   task automatic rdreg(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      while (n < 100)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
         n++;
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
      if (n == 100) errors++;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [7:0] e);
      rdreg(a);
      chk(nm, e, rd[7:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial
   begin
      repeat (4000) @(posedge aclk);
      errors++;
      finish_test();
   end

   // test sequence
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("oe", 8'h00, pin_oe);
      chk("out", 8'hFF, pin_out);
      chk("analog", 8'h00, pin_analog_en);
      chk("routed", 8'h00, {2'h0, routed});
      chk("rx", 8'h01, {7'h00, serial_rx});
      rdchk("route", PIO_ADDR_ROUTE, PIO_RST_ROUTE);
      rdchk("cfg", PIO_ADDR_OUT_CFG, 8'h00);
      rdchk("mode", PIO_ADDR_IN_MODE, 8'hFF);
      rdchk("latch", PIO_ADDR_LATCH, 8'hFF);
      $display("test reset done");
      wr(PIO_ADDR_ROUTE, 8'hFF);
      chk("wresp", {6'h00, PIO_RESP_OKAY}, {6'h00, rsp});
      rdchk("route", PIO_ADDR_ROUTE, 8'hFD);
      rdchk("unmapped", 8'h40, 8'h00);
      chk("resp", {6'h00, PIO_RESP_SLVERR}, {6'h00, rsp});
      wr(8'h40, 8'h55);
      chk("wresp", {6'h00, PIO_RESP_SLVERR}, {6'h00, rsp});
      $display("test registers done");
      ext_en <= 8'hFF;
      for (int b = 2; b < 8; b++)
      begin
         ext_val <= 8'hFF;
         wr(PIO_ADDR_ROUTE, 8'h01 << b);
         repeat (4) @(posedge aclk);
         chk("routed", 8'h01 << (b - 2), {2'h0, routed});
         ext_val <= ~(8'h01 << b);
         repeat (4) @(posedge aclk);
         chk("routed", 8'h00, {2'h0, routed});
      end
      $display("test routing done");
      ext_en <= 8'hFE;
      ext_val <= 8'hFD;
      serial_tx <= 1'b0;
      wr(PIO_ADDR_ROUTE, 8'h01);
      repeat (4) @(posedge aclk);
      chk("tx pin", 8'h00, {7'h00, pin_in[0]});
      chk("rx", 8'h00, {7'h00, serial_rx});
      serial_tx <= 1'b1;
      $display("test serial done");
      ext_en <= 8'h00;
      wr(PIO_ADDR_ROUTE, 8'h00);
      wr(PIO_ADDR_LATCH, 8'h0F);
      wr(PIO_ADDR_OUT_CFG, 8'h33);
      repeat (3) @(posedge aclk);
      chk("oe", 8'hF3, pin_oe);
      chk("level", 8'h0F, pin_in);
      rdchk("pins", PIO_ADDR_PIN_IN, 8'h0F);
      wr(PIO_ADDR_ROUTE, 8'hFF);
      repeat (3) @(posedge aclk);
      chk("oe", 8'hF3, pin_oe);
      wr(PIO_ADDR_LATCH, 8'hFF);
      wr(PIO_ADDR_OUT_CFG, 8'h00);
      $display("test drivers done");
      ext_en <= 8'hFF;
      ext_val <= 8'hFF;
      wr(PIO_ADDR_IN_MODE, 8'hEF);
      wr(PIO_ADDR_ROUTE, 8'h10);
      repeat (4) @(posedge aclk);
      chk("analog", 8'h10, pin_analog_en);
      chk("routed", 8'h00, {2'h0, routed});
      rdchk("mode", PIO_ADDR_IN_MODE, 8'hEF);
      wr(PIO_ADDR_IN_MODE, 8'hFF);
      repeat (4) @(posedge aclk);
      chk("routed", 8'h04, {2'h0, routed});
      $display("test analog done");
      wr(PIO_ADDR_IRQ_EN, 8'h00);
      wr(PIO_ADDR_OSC_CTRL, 8'h0F);
      rdchk("osc", PIO_ADDR_OSC_CTRL, 8'h0F);
      chk("fcn", 8'h07, {5'h00, fcn});
      repeat (SIM_START + 4) @(posedge aclk);
      for (int n = 0; n < 10 && rd[7] !== 1'b1; n++)
         rdreg(PIO_ADDR_OSC_CTRL);
      chk("osc", 8'h8F, rd[7:0]);
      chk("irq masked", 8'h00, {7'h00, irq});
      rdchk("status", PIO_ADDR_IRQ_STAT, 8'h01);
      wr(PIO_ADDR_IRQ_EN, 8'h01);
      repeat (2) @(posedge aclk);
      chk("irq", 8'h01, {7'h00, irq});
      wr(PIO_ADDR_IRQ_CLR, 8'h01);
      repeat (2) @(posedge aclk);
      chk("irq", 8'h00, {7'h00, irq});
      rdchk("status", PIO_ADDR_IRQ_STAT, 8'h00);
      wr(PIO_ADDR_OSC_CTRL, 8'h00);
      rdchk("osc", PIO_ADDR_OSC_CTRL, 8'h00);
      chk("fcn", 8'h00, {5'h00, fcn});
      $display("test oscillator done");
      finish_test();
   end
endmodule // pio_port_io_pin_routing_bench
